// ---- rtl/rrs_alu.sv ----
// rotate-right and subtract-with-borrow execution datapath
`timescale 1ns/1ns
`default_nettype none
module rrs_alu
  import rrs_pkg::*;
(
  input  wire logic              ref_clk,   // core clock, 250 MHz
  input  wire logic              reset_n,   // async reset, active low
  input  wire logic              op_valid,  // execute op_req this cycle
  input  wire rrs_req_t          op_req,    // operation and memory byte
  output logic                   mem_we,    // memory byte write pulse
  output logic [DATA_W-1:0]      mem_wdata, // byte to write back
  output logic [DATA_W-1:0]      acc,       // accumulator
  output rrs_flags_t             flags,     // status flags
  input  wire logic [ADDR_W-1:0] reg_addr,  // register address
  input  wire logic [DATA_W-1:0] reg_wdata, // register write data
  input  wire logic              reg_we,    // register write strobe
  input  wire logic              reg_re,    // register read strobe
  output logic [DATA_W-1:0]      reg_rdata  // read data, next cycle
);

  // ==========================================================
  // helper functions

  // rotate right by one, fill enters the top bit
  function automatic logic [DATA_W-1:0] rot_right(
    input logic [DATA_W-1:0] val,
    input logic              fill
  );
    rot_right = {fill, val[MSB_IDX:1]};
  endfunction

  // acc minus byte minus inverted carry, with flag terms
  function automatic rrs_sub_t sub_borrow(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] m,
    input logic              cin
  );
    logic [DATA_W:0] full;
    logic [NIB_W:0]  low;
    full = {1'b0, a} - {1'b0, m} - {{DATA_W{1'b0}}, ~cin};
    low  = {1'b0, a[NIB_W-1:0]} - {1'b0, m[NIB_W-1:0]}
           - {{NIB_W{1'b0}}, ~cin};
    sub_borrow.res = full[DATA_W-1:0];
    sub_borrow.c   = ~full[DATA_W];
    sub_borrow.ac  = ~low[NIB_W];
    sub_borrow.ov  = (a[MSB_IDX] ^ m[MSB_IDX])
                   & (a[MSB_IDX] ^ full[MSB_IDX]);
  endfunction

  // ==========================================================
  // datapath state

  logic [DATA_W-1:0] next_acc;
  rrs_flags_t        next_flags;
  logic              next_mem_we;
  logic [DATA_W-1:0] next_mem_wdata;
  logic [DATA_W-1:0] next_rdata;
  rrs_sub_t          sub;
  logic              sub_z;

  // subtraction terms from the registered accumulator and carry and the unregistered request byte
  assign sub   = sub_borrow(acc, op_req.operand, flags.c);
  assign sub_z = (sub.res == ZERO_BYTE);

  // next accumulator, flags and memory write
  always_comb begin
    next_acc       = acc;
    next_flags     = flags;
    next_mem_we    = 1'b0;
    next_mem_wdata = mem_wdata;
    // software writes, overridden by a same-cycle operation only where it writes the same register or flag
    if (reg_we && reg_addr == REG_ACC) begin
      next_acc = reg_wdata;
    end
    if (reg_we && reg_addr == REG_FLAGS) begin
      next_flags = rrs_flags_t'(reg_wdata[FLAG_W-1:0]);
    end
    if (op_valid) begin
      unique case (op_req.op)
        rotate_right_mem: begin
          // flags stay as they are
          next_mem_we    = 1'b1;
          next_mem_wdata = rot_right(op_req.operand,
                                     op_req.operand[0]);
        end
        rotate_right_to_acc: begin
          // no memory write for accumulator destination
          next_acc = rot_right(op_req.operand,
                               op_req.operand[0]);
        end
        rotate_right_carry_mem: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = rot_right(op_req.operand, flags.c);
          next_flags.c   = op_req.operand[0];
        end
        rotate_right_carry_to_acc: begin
          next_acc     = rot_right(op_req.operand, flags.c);
          next_flags.c = op_req.operand[0];
        end
        subtract_borrow_to_acc,
        subtract_borrow_to_mem: begin
          if (op_req.op == subtract_borrow_to_acc) begin
            next_acc = sub.res;
          end else begin
            next_mem_we    = 1'b1;
            next_mem_wdata = sub.res;
          end
          // six flags from the difference
          next_flags.c                  = sub.c;
          next_flags.nibble_carry_flag  = sub.ac;
          next_flags.overflow_flag      = sub.ov;
          next_flags.z                  = sub_z;
          next_flags.signed_result_flag = sub.ov ^ sub.res[MSB_IDX];
          next_flags.compare_zero_flag  = flags.compare_zero_flag
                                        & sub_z;
        end
        default: begin
          // unused encodings leave every register as software left it
        end
      endcase
    end
  end

  // commit result and flags on the same edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc       <= ACC_RESET;
      flags     <= rrs_flags_t'(FLAG_RESET);
      mem_we    <= 1'b0;
      mem_wdata <= ZERO_BYTE;
    end else begin
      acc       <= next_acc;
      flags     <= next_flags;
      mem_we    <= next_mem_we;
      mem_wdata <= next_mem_wdata;
    end
  end

  // ==========================================================
  // register read port

  // read data selected from state before this edge
  always_comb begin
    next_rdata = ZERO_BYTE;
    if (reg_re) begin
      unique case (reg_addr)
        REG_ACC:   next_rdata = acc;
        REG_FLAGS: next_rdata = {{FLAG_PAD{1'b0}}, flags};
        default:   next_rdata = ZERO_BYTE;
      endcase
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= ZERO_BYTE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // issue of each operation
  sequence rr_mem_s;
    op_valid && op_req.op == rotate_right_mem;
  endsequence
  sequence rr_acc_s;
    op_valid && op_req.op == rotate_right_to_acc;
  endsequence
  sequence rrc_mem_s;
    op_valid && op_req.op == rotate_right_carry_mem;
  endsequence
  sequence rrc_acc_s;
    op_valid && op_req.op == rotate_right_carry_to_acc;
  endsequence
  sequence sbc_acc_s;
    op_valid && op_req.op == subtract_borrow_to_acc;
  endsequence
  sequence sbc_mem_s;
    op_valid && op_req.op == subtract_borrow_to_mem;
  endsequence

  rot_mem_data_a: assert property (
    rr_mem_s |=> mem_we && mem_wdata ==
      {$past(op_req.operand[0]), $past(op_req.operand[7:1])})
    else $error("rotate to memory gave wrong byte");

  rot_mem_flags_a: assert property (
    rr_mem_s and !reg_we |=> $stable(flags))
    else $error("rotate to memory changed flags");

  rot_acc_data_a: assert property (
    rr_acc_s |=> acc ==
      {$past(op_req.operand[0]), $past(op_req.operand[7:1])}
      && $stable(flags))
    else $error("rotate to accumulator wrong");

  acc_dest_nowrite_a: assert property (
    (rr_acc_s or rrc_acc_s or sbc_acc_s) |=> !mem_we)
    else $error("accumulator op wrote memory");

  rrc_mem_ring_a: assert property (
    rrc_mem_s |=> mem_we
      && mem_wdata == {$past(flags.c), $past(op_req.operand[7:1])}
      && flags.c == $past(op_req.operand[0]))
    else $error("carry rotate to memory wrong");

  rrc_acc_ring_a: assert property (
    rrc_acc_s and !reg_we |=>
      acc == {$past(flags.c), $past(op_req.operand[7:1])}
      && flags.c == $past(op_req.operand[0])
      && flags[FLAG_W-1:1] == $past(flags[FLAG_W-1:1]))
    else $error("carry rotate to accumulator wrong");

  sbc_acc_diff_a: assert property (
    sbc_acc_s |=> acc == 8'($past(acc) - $past(op_req.operand)
                          - 8'(!$past(flags.c))))
    else $error("borrow subtract to accumulator wrong");

  sbc_mem_diff_a: assert property (
    sbc_mem_s and !reg_we |=> mem_we && $stable(acc)
      && mem_wdata == 8'($past(acc) - $past(op_req.operand)
                       - 8'(!$past(flags.c))))
    else $error("borrow subtract to memory wrong");

  sbc_carry_a: assert property (
    (sbc_acc_s or sbc_mem_s) |=> flags.c ==
      ({1'b0, $past(acc)} >= ({1'b0, $past(op_req.operand)}
                              + 9'(!$past(flags.c)))))
    else $error("subtract carry wrong");

  sbc_flags_a: assert property (
    sbc_mem_s |=> flags.z == (mem_wdata == ZERO_BYTE)
      && flags.signed_result_flag ==
         (flags.overflow_flag ^ mem_wdata[MSB_IDX])
      && flags.overflow_flag ==
         (($past(acc[7]) ^ $past(op_req.operand[7]))
          & ($past(acc[7]) ^ mem_wdata[7])))
    else $error("subtract flags wrong");

  write_single_cycle_a: assert property (
    mem_we |-> $past(op_valid) && $past(op_req.op) inside
      {rotate_right_mem, rotate_right_carry_mem, subtract_borrow_to_mem})
    else $error("memory write without matching op");

  // a rotate to memory never disturbs the accumulator
  rot_mem_acc_a: assert property (
    rr_mem_s and !reg_we |=> $stable(acc))
    else $error("rotate to memory changed accumulator");

  // the memory carry rotate touches only carry and the written byte
  rrc_mem_only_c_a: assert property (
    rrc_mem_s and !reg_we |=> $stable(acc)
      && flags[FLAG_W-1:1] == $past(flags[FLAG_W-1:1]))
    else $error("carry rotate to memory touched other state");

  // zero, sign and overflow flags follow the accumulator result
  sbc_acc_flags_a: assert property (
    sbc_acc_s |=> flags.z == (acc == ZERO_BYTE)
      && flags.signed_result_flag ==
         (flags.overflow_flag ^ acc[MSB_IDX])
      && flags.overflow_flag ==
         (($past(acc[MSB_IDX]) ^ $past(op_req.operand[MSB_IDX]))
          & ($past(acc[MSB_IDX]) ^ acc[MSB_IDX])))
    else $error("subtract to accumulator flags wrong");

  // nibble carry is no borrow out of the low half, compare zero accumulates
  sbc_nibble_cz_a: assert property (
    (sbc_acc_s or sbc_mem_s) |=>
      flags.nibble_carry_flag ==
        ({1'b0, $past(acc[NIB_W-1:0])} >=
         ({1'b0, $past(op_req.operand[NIB_W-1:0])} + 5'(!$past(flags.c))))
      && flags.compare_zero_flag == ($past(flags.compare_zero_flag) && flags.z))
    else $error("subtract nibble or compare flags wrong");

  // a software write to the accumulator lands when no op is issued
  acc_write_a: assert property (
    reg_we && reg_addr == REG_ACC && !op_valid |=> acc == $past(reg_wdata))
    else $error("accumulator register write lost");

  // read data is zero outside the cycle after a read strobe
  rdata_idle_a: assert property (
    !reg_re |=> reg_rdata == ZERO_BYTE)
    else $error("read data present without a read");

  // a read returns the accumulator as it stood before the edge
  rdata_acc_a: assert property (
    reg_re && reg_addr == REG_ACC |=> reg_rdata == $past(acc))
    else $error("accumulator read data wrong");

endmodule
`default_nettype wire

// ---- rtl/rrs_pkg.sv ----
// constants and types for the rotate-right / subtract-borrow datapath
// Operation
// - rotate_right_mem: byte rotates right, flags untouched
// - rotate_right_to_acc: rotated byte into accumulator, no flags
// - accumulator destination leaves memory byte unmodified
// - rotate_right_carry_mem: nine-bit ring, carry only
// - rotate_right_carry_to_acc: ring result to accumulator, carry only
// - subtract_borrow_to_acc: acc minus byte minus inverted carry
// - subtract_borrow_to_mem: same difference into memory byte
// - subtract carry cleared on negative, else set
// - subtract updates ov, z, ac, c, sc, cz only
package rrs_pkg;

  // ==========================================================
  // widths, register map and reset values
  localparam int          DATA_W     = 8;
  localparam int          ADDR_W     = 2;
  localparam int          FLAG_W     = 6;
  localparam int          FLAG_PAD   = DATA_W - FLAG_W;
  localparam int          MSB_IDX    = DATA_W - 1;
  localparam int          NIB_W      = 4;
  localparam logic [1:0]  REG_ACC    = 2'h0;
  localparam logic [1:0]  REG_FLAGS  = 2'h1;
  localparam logic [7:0]  ACC_RESET  = 8'h00;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam logic [5:0]  FLAG_RESET = 6'h00;

  // ==========================================================
  // operations carried out by the datapath
  typedef enum logic [2:0] {
    rotate_right_mem,
    rotate_right_to_acc,
    rotate_right_carry_mem,
    rotate_right_carry_to_acc,
    subtract_borrow_to_acc,
    subtract_borrow_to_mem
  } rrs_op_t;

  // one instruction with its memory operand
  typedef struct packed {
    rrs_op_t     op;
    logic [7:0]  operand;
  } rrs_req_t;

  // status flags, carry in bit 0
  typedef struct packed {
    logic compare_zero_flag;
    logic signed_result_flag;
    logic overflow_flag;
    logic z;
    logic nibble_carry_flag;
    logic c;
  } rrs_flags_t;

  // result of the borrow subtraction
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       ac;
    logic       ov;
  } rrs_sub_t;

endpackage

// ---- testbench/test_rotate_right_subtract_borrow_alu.sv ----
// self-checking bench for the rotate-right / subtract-borrow datapath
`timescale 1ns/1ns
`default_nettype none
module test_rotate_right_subtract_borrow_alu;
  import rrs_pkg::*;
  // ==========================================================
  // stimulus, observed outputs and expected state
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       op_valid = 1'b0;
  rrs_req_t   op_req = '0;
  logic       mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] acc;
  rrs_flags_t flags;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_we = 1'b0;
  logic       reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] ea;
  logic [7:0] em;
  logic       ew;
  rrs_flags_t ef;
  int         err_total = 0;
  int         compares = 0;

  rrs_alu i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .op_valid(op_valid), .op_req(op_req),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc), .flags(flags),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));

  // 4 ns core clock
  always #2 ref_clk = ~ref_clk;

  // ==========================================================
  // compares and closing report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // register bus and operation drivers
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask
  task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 chk_byte(reg_rdata, exp);
  endtask
  task automatic set_state(input logic [7:0] a, input rrs_flags_t f);
    reg_write(REG_ACC, a);
    reg_write(REG_FLAGS, {2'b00, f});
    ea = a;
    ef = f;
  endtask
  // expected effect of one operation on accumulator, flags and memory
  task automatic model(input rrs_op_t op, input logic [7:0] m);
    logic [8:0] d;
    logic [4:0] n;
    logic       ov;
    d = {1'b0, ea} - {1'b0, m} - {8'h00, ~ef.c};
    n = {1'b0, ea[3:0]} - {1'b0, m[3:0]} - {4'h0, ~ef.c};
    ov = (ea[7] ^ m[7]) & (d[7] ^ ea[7]);
    ew = 1'b0;
    case (op)
      rotate_right_mem, rotate_right_carry_mem: begin
        ew = 1'b1;
        em = {(op == rotate_right_mem) ? m[0] : ef.c, m[7:1]};
      end
      rotate_right_to_acc: ea = {m[0], m[7:1]};
      rotate_right_carry_to_acc: ea = {ef.c, m[7:1]};
      subtract_borrow_to_acc, subtract_borrow_to_mem: begin
        ef.c = ~d[8];
        ef.nibble_carry_flag = ~n[4];
        ef.z = (d[7:0] == 8'h00);
        ef.overflow_flag = ov;
        ef.signed_result_flag = ov ^ d[7];
        ef.compare_zero_flag = ef.compare_zero_flag & ef.z;
        ew = (op == subtract_borrow_to_mem);
        if (ew) em = d[7:0];
        else ea = d[7:0];
      end
      default: ;
    endcase
    if (op == rotate_right_carry_mem || op == rotate_right_carry_to_acc) begin
      ef.c = m[0];
    end
  endtask
  // outputs one cycle after the op, then the write pulse gone
  task automatic check_out;
    chk_bit(mem_we, ew);
    chk_byte(mem_wdata, em);
    chk_byte(acc, ea);
    chk_byte({2'b00, flags}, {2'b00, ef});
    @(posedge ref_clk);
    #1 chk_bit(mem_we, 1'b0);
  endtask
  task automatic do_op(input rrs_op_t op, input logic [7:0] m);
    model(op, m);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_req <= '{op: op, operand: m};
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1 check_out();
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_regs;
    chk_byte(acc, ACC_RESET);
    chk_byte({2'b00, flags}, {2'b00, FLAG_RESET});
    chk_bit(mem_we, 1'b0);
    chk_byte(mem_wdata, ZERO_BYTE);
    chk_byte(reg_rdata, ZERO_BYTE);
    set_state(8'hA5, rrs_flags_t'(6'h2B));
    reg_write(2'h2, 8'h3C);
    reg_read(REG_ACC, 8'hA5);
    @(posedge ref_clk);
    #1 chk_byte(reg_rdata, 8'h00);
    reg_read(REG_FLAGS, 8'h2B);
    reg_read(2'h3, 8'h00);
  endtask
  task automatic sc_rotate;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 4; k++) begin
        set_state(8'h5A, rrs_flags_t'({5'h1F, c[0]}));
        do_op(rrs_op_t'(k[2:0]), c ? 8'h7E : 8'h81);
      end
    end
  endtask
  task automatic sc_subtract;
    logic [7:0] ta [6] = '{8'h50, 8'h20, 8'h80, 8'h00, 8'h10, 8'h7F};
    logic [7:0] tm [6] = '{8'h20, 8'h50, 8'h01, 8'h00, 8'h0F, 8'hFF};
    logic [5:0] tc = 6'b100111;
    for (int i = 0; i < 6; i++) begin
      for (int k = 4; k < 6; k++) begin
        set_state(ta[i], rrs_flags_t'({5'h1A, tc[i]}));
        do_op(rrs_op_t'(k[2:0]), tm[i]);
      end
    end
  endtask
  task automatic sc_back_to_back;
    set_state(8'h03, rrs_flags_t'(6'h20));
    model(subtract_borrow_to_acc, 8'h01);
    model(subtract_borrow_to_mem, 8'h01);
    model(rotate_right_carry_to_acc, 8'h02);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_req <= '{op: subtract_borrow_to_acc, operand: 8'h01};
    @(posedge ref_clk);
    op_req <= '{op: subtract_borrow_to_mem, operand: 8'h01};
    @(posedge ref_clk);
    op_req <= '{op: rotate_right_carry_to_acc, operand: 8'h02};
    #1 chk_bit(mem_we, 1'b1);
    chk_byte(mem_wdata, em);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1 check_out();
  endtask
  // unused operation codes change nothing
  task automatic sc_unused;
    set_state(8'h96, rrs_flags_t'(6'h15));
    do_op(rrs_op_t'(3'h6), 8'h33);
    do_op(rrs_op_t'(3'h7), 8'hCC);
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 sc_regs();
    sc_rotate();
    sc_subtract();
    sc_back_to_back();
    sc_unused();
    test_done();
  end
endmodule
`default_nettype wire
